//--- hdl/efm_params.svh
/*
 * Constants of the frame-check and lane-marker block: framing bytes, CRC
 * constants, limits and the default lane marker values.
 * Assumes inclusion by bare name from every file that needs them.
 */
`ifndef EFM_PARAMS_SVH
`define EFM_PARAMS_SVH

`define EFM_PREAMBLE_BYTE 8'h55
`define EFM_DELIM_BYTE 8'hD5
`define EFM_PREAMBLE_LEN 3'h7
`define EFM_CRC_INIT 32'hFFFFFFFF
`define EFM_CRC_POLY 32'hEDB88320
`define EFM_CRC_RESIDUE 32'hDEBB20E3
`define EFM_FCS_LAST 2'h3
`define EFM_FCS_BYTES 3'h4
`define EFM_SHORT_LIMIT 4'h8
`define EFM_LEN_SAT 4'hF
`define EFM_LANES 20
`define EFM_LANE_LAST 5'h13
`define EFM_SPACING_DEFAULT 16'h3FFF
`define EFM_FIFO_DEPTH 8
`define EFM_MK0 64'hC16821003E97DE00
`define EFM_MK1 64'h9D718E00628E7100
`define EFM_MK2 64'h594BE800A6B41700
`define EFM_MK3 64'h4D957B00B26A8400
`define EFM_MK4 64'hF50709000AF8F600
`define EFM_MK5 64'hDD14C20022EB3D00
`define EFM_MK6 64'h9A4A260065B5D900
`define EFM_MK7 64'h7B45660084BA9900
`define EFM_MK8 64'hA02476005FDB8900
`define EFM_MK9 64'h68C9FB0097360400
`define EFM_MK10 64'hFD6C990002936600
`define EFM_MK11 64'hB9915500466EAA00
`define EFM_MK12 64'h5CB9B200A3464D00
`define EFM_MK13 64'h1AF8BD00E5074200
`define EFM_MK14 64'h83C7CA007C383500
`define EFM_MK15 64'h3536CD00CAC93200
`define EFM_MK16 64'hC4314C003BCEB300
`define EFM_MK17 64'hADD6B70052294800
`define EFM_MK18 64'h5F662A00A099D500
`define EFM_MK19 64'hC0F0E5003F0F1A00

`endif

//--- hdl/efm_pkg.sv
/*
 * Types shared by the frame-check and lane-marker block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package efm_pkg;
    typedef logic [7:0] efm_byte_t;
    typedef enum logic
    {
        EFM_TX_DATA = 1'b0,
        EFM_TX_FCS = 1'b1
    } efm_tx_state_t;
    typedef enum logic [1:0]
    {
        EFM_RX_PRE = 2'b00,
        EFM_RX_SFD = 2'b01,
        EFM_RX_DATA = 2'b11,
        EFM_RX_FLUSH = 2'b10
    } efm_rx_state_t;
endpackage

//--- hdl/efm_fifo.sv
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes DEPTH is a power of two and one clock for both sides.
 */
`timescale 1ns/100ps
module efm_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] wr_d;
    logic [AW:0] rd_q;
    logic [AW:0] rd_d;
    logic push;
    logic pop;

    // Full compares the wrap bit as well, so all DEPTH slots are usable.
    assign in_ready = (wr_q ^ rd_q) != {1'b1, {AW{1'b0}}};
    assign out_valid = wr_q != rd_q;
    assign out_data = mem_q[rd_q[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb
    begin
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_q <= '0;
            rd_q <= '0;
            for (int i = 0; i < DEPTH; i++)
            begin
                mem_q[i] <= '0;
            end
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            if (push)
            begin
                mem_q[wr_q[AW-1:0]] <= in_data;
            end
        end
    end
endmodule

//--- hdl/efm_crc32.sv
/*
 * Byte-wide reflected Ethernet CRC-32 accumulator.
 * Assumes bytes arrive least significant bit first on the line.
 */
`timescale 1ns/100ps
`include "efm_params.svh"
module efm_crc32 (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic en,
    input wire efm_pkg::efm_byte_t data,
    output logic [31:0] crc_q,
    output logic [31:0] crc_nxt
);
    logic [31:0] crc_d;

    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b);
        logic [31:0] r;
        r = c ^ {24'h000000, b};
        for (int i = 0; i < 8; i++)
        begin
            r = r[0] ? ((r >> 1) ^ `EFM_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    always_comb
    begin
        crc_nxt = crc_step(crc_q, data);
        crc_d = clr ? `EFM_CRC_INIT : (en ? crc_nxt : crc_q);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            crc_q <= `EFM_CRC_INIT;
        end
        else
        begin
            crc_q <= crc_d;
        end
    end
endmodule

//--- hdl/efm_top.sv
/*
 * Transmit FCS insertion and checking, lane marker scheduling, receive
 * preamble and delimiter checks and receive FCS removal on byte streams.
 * Assumes configuration inputs come from logic on clk and stay stable.
 */
// Function
// - Insertion on appends the computed FCS to each frame; off appends nothing.
// - Ignore setting, only with insertion off, counts bad-FCS frames as good.
// - Ignore off, insertion off: bad FCS flags bad and stomped, not good.
// - Marker spacing in words equals the configured value plus one.
// - Lanes 0 to 2 markers are configurable, with their default values.
// - Lanes 3 to 5 markers are configurable, with their default values.
// - Lanes 6 to 8 markers are configurable, with their default values.
// - Lanes 9 to 11 markers are configurable, with their default values.
// - Lanes 12 to 14 markers are configurable, with their default values.
// - Lanes 15 to 17 markers are configurable, with their default values.
// - Lanes 18 and 19 markers are configurable, with their default values.
// - Preamble check on verifies each received preamble; off skips it.
// - Delimiter check on verifies each start delimiter; off skips it.
// - Strip on removes the received FCS; off delivers it intact.
// - Frames of eight bytes or fewer keep their FCS even with strip on.
`timescale 1ns/100ps
`include "efm_params.svh"
module efm_top #(
    parameter int FIFO_DEPTH = `EFM_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tx_fcs_insert_on,
    input wire logic tx_fcs_ignore_on,
    input wire logic [15:0] tx_marker_spacing_m1,
    input wire logic tx_marker_custom_on,
    input wire logic [`EFM_LANES*64-1:0] tx_lane_marker_value_n,
    input wire logic tx_in_valid,
    output logic tx_in_ready,
    input wire efm_pkg::efm_byte_t tx_in_data,
    input wire logic tx_in_last,
    output logic tx_out_valid,
    input wire logic tx_out_ready,
    output efm_pkg::efm_byte_t tx_out_data,
    output logic tx_out_last,
    output logic tx_good_pkt,
    output logic tx_bad_fcs,
    output logic crc_stomped_flag,
    output logic tx_marker_valid,
    output logic [4:0] tx_marker_lane,
    output logic [63:0] tx_marker_data,
    input wire logic rx_preamble_verify_on,
    input wire logic rx_delimiter_verify_on,
    input wire logic rx_crc_strip_on,
    input wire logic rx_in_valid,
    output logic rx_in_ready,
    input wire efm_pkg::efm_byte_t rx_in_data,
    input wire logic rx_in_last,
    output logic rx_out_valid,
    output efm_pkg::efm_byte_t rx_out_data,
    output logic rx_out_last,
    output logic rx_preamble_err,
    output logic rx_delimiter_err
);
    localparam logic [63:0] LANE_DFLT [`EFM_LANES] = '{`EFM_MK0, `EFM_MK1, `EFM_MK2,
        `EFM_MK3, `EFM_MK4, `EFM_MK5, `EFM_MK6, `EFM_MK7, `EFM_MK8, `EFM_MK9, `EFM_MK10,
        `EFM_MK11, `EFM_MK12, `EFM_MK13, `EFM_MK14, `EFM_MK15, `EFM_MK16, `EFM_MK17,
        `EFM_MK18, `EFM_MK19};

    // Transmit side state.
    efm_pkg::efm_tx_state_t tx_state_q, tx_state_d;
    logic [1:0] fcs_cnt_q, fcs_cnt_d;
    logic tx_valid_q, tx_valid_d, tx_last_q, tx_last_d;
    efm_pkg::efm_byte_t tx_data_q, tx_data_d;
    logic good_q, good_d, bad_q, bad_d;
    logic fifo_valid, fifo_ready, can_load, crc_clr, crc_en, last_take;
    logic [8:0] fifo_data;
    logic [31:0] crc_q, crc_nxt;

    efm_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(tx_in_valid),
        .in_ready(tx_in_ready),
        .in_data({tx_in_last, tx_in_data}),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready),
        .out_data(fifo_data)
    );

    efm_crc32 u_crc (
        .clk(clk),
        .rst_n(rst_n),
        .clr(crc_clr),
        .en(crc_en),
        .data(fifo_data[7:0]),
        .crc_q(crc_q),
        .crc_nxt(crc_nxt)
    );

    // The insertion setting is read live; its value when a frame's last byte is taken decides that frame's FCS.
    always_comb
    begin
        tx_state_d = tx_state_q;
        fcs_cnt_d = fcs_cnt_q;
        tx_valid_d = tx_valid_q && !tx_out_ready;
        tx_last_d = tx_last_q;
        tx_data_d = tx_data_q;
        good_d = 1'b0;
        bad_d = 1'b0;
        crc_clr = 1'b0;
        crc_en = 1'b0;
        fifo_ready = 1'b0;
        can_load = !tx_valid_q || tx_out_ready;
        last_take = 1'b0;
        unique case (tx_state_q)
            efm_pkg::EFM_TX_DATA:
            begin
                fifo_ready = can_load;
                if (fifo_valid && can_load)
                begin
                    tx_valid_d = 1'b1;
                    tx_data_d = fifo_data[7:0];
                    tx_last_d = fifo_data[8] && !tx_fcs_insert_on;
                    crc_en = 1'b1;
                    if (fifo_data[8])
                    begin
                        last_take = 1'b1;
                        if (tx_fcs_insert_on)
                        begin
                            tx_state_d = efm_pkg::EFM_TX_FCS;
                            fcs_cnt_d = 2'h0;
                        end
                        else
                        begin
                            crc_clr = 1'b1;
                            good_d = (crc_nxt == `EFM_CRC_RESIDUE) || tx_fcs_ignore_on;
                            bad_d = (crc_nxt != `EFM_CRC_RESIDUE) && !tx_fcs_ignore_on;
                        end
                    end
                end
            end
            efm_pkg::EFM_TX_FCS:
            begin
                if (can_load)
                begin
                    tx_valid_d = 1'b1;
                    tx_data_d = ~crc_q[8*fcs_cnt_q +: 8];
                    tx_last_d = fcs_cnt_q == `EFM_FCS_LAST;
                    fcs_cnt_d = fcs_cnt_q + 2'h1;
                    if (fcs_cnt_q == `EFM_FCS_LAST)
                    begin
                        tx_state_d = efm_pkg::EFM_TX_DATA;
                        crc_clr = 1'b1;
                        good_d = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_state_q <= efm_pkg::EFM_TX_DATA;
            fcs_cnt_q <= 2'h0;
            tx_valid_q <= 1'b0;
            tx_last_q <= 1'b0;
            tx_data_q <= 8'h00;
            good_q <= 1'b0;
            bad_q <= 1'b0;
        end
        else
        begin
            tx_state_q <= tx_state_d;
            fcs_cnt_q <= fcs_cnt_d;
            tx_valid_q <= tx_valid_d;
            tx_last_q <= tx_last_d;
            tx_data_q <= tx_data_d;
            good_q <= good_d;
            bad_q <= bad_d;
        end
    end

    assign tx_out_valid = tx_valid_q;
    assign tx_out_data = tx_data_q;
    assign tx_out_last = tx_last_q;
    assign tx_good_pkt = good_q;
    assign tx_bad_fcs = bad_q;
    assign crc_stomped_flag = bad_q;

    // Lane marker scheduler: one marker slot after every spacing plus one words.
    logic [63:0] lane_val [`EFM_LANES];
    logic [16:0] mk_cnt_q, mk_cnt_d;
    logic [4:0] mk_lane_q, mk_lane_d;
    logic mk_valid_q, mk_valid_d;
    logic [63:0] mk_data_q, mk_data_d;
    logic [4:0] mk_lane_out_q, mk_lane_out_d;
    logic mk_slot;

    for (genvar g = 0; g < `EFM_LANES; g++)
    begin : g_lane
        assign lane_val[g] = tx_marker_custom_on ? tx_lane_marker_value_n[64*g +: 64]
            : LANE_DFLT[g];
    end

    always_comb
    begin
        mk_slot = mk_cnt_q >= {1'b0, tx_marker_spacing_m1} + 17'h1;
        mk_cnt_d = mk_slot ? 17'h0 : mk_cnt_q + 17'h1;
        mk_lane_d = mk_lane_q;
        mk_valid_d = mk_slot;
        mk_data_d = mk_data_q;
        mk_lane_out_d = mk_lane_out_q;
        if (mk_slot)
        begin
            mk_data_d = lane_val[mk_lane_q];
            mk_lane_out_d = mk_lane_q;
            mk_lane_d = (mk_lane_q == `EFM_LANE_LAST) ? 5'h0 : mk_lane_q + 5'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mk_cnt_q <= 17'h0;
            mk_lane_q <= 5'h0;
            mk_valid_q <= 1'b0;
            mk_data_q <= 64'h0;
            mk_lane_out_q <= 5'h0;
        end
        else
        begin
            mk_cnt_q <= mk_cnt_d;
            mk_lane_q <= mk_lane_d;
            mk_valid_q <= mk_valid_d;
            mk_data_q <= mk_data_d;
            mk_lane_out_q <= mk_lane_out_d;
        end
    end

    assign tx_marker_valid = mk_valid_q;
    assign tx_marker_lane = mk_lane_out_q;
    assign tx_marker_data = mk_data_q;

    // Receive side: four bytes are held back so the FCS can be dropped at the end.
    efm_pkg::efm_rx_state_t rx_state_q, rx_state_d;
    logic [2:0] pre_cnt_q, pre_cnt_d, hcnt_q, hcnt_d;
    logic [3:0] len_q, len_d;
    efm_pkg::efm_byte_t hold_q [4];
    efm_pkg::efm_byte_t hold_d [4];
    logic ro_valid_q, ro_valid_d, ro_last_q, ro_last_d, pe_q, pe_d, de_q, de_d;
    efm_pkg::efm_byte_t ro_data_q, ro_data_d;
    logic rx_take;

    assign rx_in_ready = rx_state_q != efm_pkg::EFM_RX_FLUSH;
    assign rx_take = rx_in_valid && rx_in_ready;

    always_comb
    begin
        rx_state_d = rx_state_q;
        pre_cnt_d = pre_cnt_q;
        hcnt_d = hcnt_q;
        len_d = len_q;
        hold_d = hold_q;
        ro_valid_d = 1'b0;
        ro_last_d = 1'b0;
        ro_data_d = ro_data_q;
        pe_d = 1'b0;
        de_d = 1'b0;
        unique case (rx_state_q)
            efm_pkg::EFM_RX_PRE:
            begin
                if (rx_take)
                begin
                    pe_d = rx_preamble_verify_on && rx_in_data != `EFM_PREAMBLE_BYTE;
                    pre_cnt_d = pre_cnt_q + 3'h1;
                    if (pre_cnt_q == `EFM_PREAMBLE_LEN - 3'h1)
                    begin
                        rx_state_d = efm_pkg::EFM_RX_SFD;
                    end
                end
            end
            efm_pkg::EFM_RX_SFD:
            begin
                if (rx_take)
                begin
                    de_d = rx_delimiter_verify_on && rx_in_data != `EFM_DELIM_BYTE;
                    rx_state_d = efm_pkg::EFM_RX_DATA;
                    pre_cnt_d = 3'h0;
                    hcnt_d = 3'h0;
                    len_d = 4'h0;
                end
            end
            efm_pkg::EFM_RX_DATA:
            begin
                if (rx_take)
                begin
                    len_d = (len_q == `EFM_LEN_SAT) ? len_q : len_q + 4'h1;
                    if (hcnt_q == `EFM_FCS_BYTES)
                    begin
                        ro_valid_d = 1'b1;
                        ro_data_d = hold_q[0];
                        hold_d[0] = hold_q[1];
                        hold_d[1] = hold_q[2];
                        hold_d[2] = hold_q[3];
                        hold_d[3] = rx_in_data;
                    end
                    else
                    begin
                        hold_d[hcnt_q[1:0]] = rx_in_data;
                        hcnt_d = hcnt_q + 3'h1;
                    end
                    if (rx_in_last)
                    begin
                        if (rx_crc_strip_on && len_d > `EFM_SHORT_LIMIT)
                        begin
                            ro_last_d = 1'b1;
                            rx_state_d = efm_pkg::EFM_RX_PRE;
                        end
                        else
                        begin
                            rx_state_d = efm_pkg::EFM_RX_FLUSH;
                        end
                    end
                end
            end
            efm_pkg::EFM_RX_FLUSH:
            begin
                ro_valid_d = 1'b1;
                ro_data_d = hold_q[0];
                ro_last_d = hcnt_q == 3'h1;
                hold_d[0] = hold_q[1];
                hold_d[1] = hold_q[2];
                hold_d[2] = hold_q[3];
                hcnt_d = hcnt_q - 3'h1;
                if (hcnt_q == 3'h1)
                begin
                    rx_state_d = efm_pkg::EFM_RX_PRE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_state_q <= efm_pkg::EFM_RX_PRE;
            pre_cnt_q <= 3'h0;
            hcnt_q <= 3'h0;
            len_q <= 4'h0;
            hold_q <= '{default: 8'h00};
            ro_valid_q <= 1'b0;
            ro_last_q <= 1'b0;
            ro_data_q <= 8'h00;
            pe_q <= 1'b0;
            de_q <= 1'b0;
        end
        else
        begin
            rx_state_q <= rx_state_d;
            pre_cnt_q <= pre_cnt_d;
            hcnt_q <= hcnt_d;
            len_q <= len_d;
            hold_q <= hold_d;
            ro_valid_q <= ro_valid_d;
            ro_last_q <= ro_last_d;
            ro_data_q <= ro_data_d;
            pe_q <= pe_d;
            de_q <= de_d;
        end
    end

    assign rx_out_valid = ro_valid_q;
    assign rx_out_data = ro_data_q;
    assign rx_out_last = ro_last_q;
    assign rx_preamble_err = pe_q;
    assign rx_delimiter_err = de_q;

    property p_ins_goes_fcs;
        @(posedge clk) disable iff (!rst_n)
        (last_take && tx_fcs_insert_on) |=> (tx_state_q == efm_pkg::EFM_TX_FCS) && !tx_last_q;
    endproperty
    a_ins_goes_fcs: assert property (p_ins_goes_fcs) else $error("FCS not appended");

    property p_noins_last;
        @(posedge clk) disable iff (!rst_n)
        (last_take && !tx_fcs_insert_on) |=> tx_last_q && tx_valid_q && (good_q || bad_q);
    endproperty
    a_noins_last: assert property (p_noins_last) else $error("Frame not ended as sent");

    property p_ignore_good;
        @(posedge clk) disable iff (!rst_n)
        (last_take && !tx_fcs_insert_on && tx_fcs_ignore_on) |=> good_q && !bad_q;
    endproperty
    a_ignore_good: assert property (p_ignore_good) else $error("Ignored FCS not good");

    property p_bad_flags;
        @(posedge clk) disable iff (!rst_n)
        bad_q |-> crc_stomped_flag && !good_q && !$past(tx_fcs_ignore_on);
    endproperty
    a_bad_flags: assert property (p_bad_flags) else $error("Bad FCS flags wrong");

    property p_marker_spacing;
        @(posedge clk) disable iff (!rst_n)
        $rose(mk_valid_q) |=> !mk_valid_q [*1] ##0 (mk_cnt_q == 17'h1);
    endproperty
    a_marker_spacing: assert property (p_marker_spacing) else $error("Marker spacing wrong");

    property p_lane0_default;
        @(posedge clk) disable iff (!rst_n)
        (mk_slot && !tx_marker_custom_on && mk_lane_q == 5'h0) |=> mk_data_q == `EFM_MK0;
    endproperty
    a_lane0_default: assert property (p_lane0_default) else $error("Lane 0 marker wrong");

    property p_pre_err;
        @(posedge clk) disable iff (!rst_n)
        pe_q |-> $past(rx_preamble_verify_on) && $past(rx_state_q) == efm_pkg::EFM_RX_PRE;
    endproperty
    a_pre_err: assert property (p_pre_err) else $error("Preamble error unjustified");

    property p_sfd_err;
        @(posedge clk) disable iff (!rst_n)
        de_q |-> $past(rx_delimiter_verify_on) && $past(rx_in_data) != `EFM_DELIM_BYTE;
    endproperty
    a_sfd_err: assert property (p_sfd_err) else $error("Delimiter error unjustified");

    property p_short_keeps;
        @(posedge clk) disable iff (!rst_n)
        (rx_take && rx_in_last && rx_state_q == efm_pkg::EFM_RX_DATA && len_d <= `EFM_SHORT_LIMIT)
            |=> rx_state_q == efm_pkg::EFM_RX_FLUSH;
    endproperty
    a_short_keeps: assert property (p_short_keeps) else $error("Short frame lost FCS");
endmodule

//--- test/efm_local_packet_bus_sink.sv
/* Sink for the transmit byte stream, standing for user logic on the bus.
   Assumes the bench seeds $urandom once before traffic starts. */
`timescale 1ns/100ps
module efm_pkt_sink (
    input wire logic clk,
    input wire logic stall_on,
    output logic ready
);
    // Ready at one cycle in four backs the FIFO up until it refuses.
    // One process owns ready, so it never has two drivers.
    initial
    begin
        ready = 1'b1;
        forever @(negedge clk) ready <= stall_on ? ($urandom_range(3) == 0) : 1'b1;
    end
endmodule

//--- test/tb.sv
/* Self-checking bench for efm_top: transmit FCS, markers and receive path.
   Assumes efm_pkt_sink drives the transmit output ready. */
`timescale 1ns/100ps
`include "efm_params.svh"
module tb;
    typedef efm_pkg::efm_byte_t b_t;
    logic clk = 0, rst_n = 0, ins = 1, ign = 0, cus = 0, stall = 0, pv = 0, dv = 0;
    logic strip = 1, tv = 0, tl = 0, rv = 0, rl = 0, tir, tov, tor, tol, good, bad;
    logic stomp, mv, rir, rov, rol, pe, de;
    logic [4:0] ml;
    logic [63:0] md;
    logic [15:0] sp = 16'h0004;
    logic [1279:0] mk = '0;
    b_t td = '0, rd = '0, tod, rod;
    b_t txq[$], rxq[$];
    int ng, nb, ns, npe, nde, ntl, nrl, tla, rla, failures = 0, n_compared = 0;
    logic [63:0] dflt[20] = '{`EFM_MK0, `EFM_MK1, `EFM_MK2, `EFM_MK3, `EFM_MK4, `EFM_MK5,
        `EFM_MK6, `EFM_MK7, `EFM_MK8, `EFM_MK9, `EFM_MK10, `EFM_MK11, `EFM_MK12, `EFM_MK13,
        `EFM_MK14, `EFM_MK15, `EFM_MK16, `EFM_MK17, `EFM_MK18, `EFM_MK19};
    efm_top efm_top_i (.clk(clk), .rst_n(rst_n), .tx_fcs_insert_on(ins),
        .tx_fcs_ignore_on(ign), .tx_marker_spacing_m1(sp), .tx_marker_custom_on(cus),
        .tx_lane_marker_value_n(mk), .tx_in_valid(tv), .tx_in_ready(tir), .tx_in_data(td),
        .tx_in_last(tl), .tx_out_valid(tov), .tx_out_ready(tor), .tx_out_data(tod),
        .tx_out_last(tol), .tx_good_pkt(good), .tx_bad_fcs(bad), .crc_stomped_flag(stomp),
        .tx_marker_valid(mv), .tx_marker_lane(ml), .tx_marker_data(md),
        .rx_preamble_verify_on(pv), .rx_delimiter_verify_on(dv), .rx_crc_strip_on(strip),
        .rx_in_valid(rv), .rx_in_ready(rir), .rx_in_data(rd), .rx_in_last(rl),
        .rx_out_valid(rov), .rx_out_data(rod), .rx_out_last(rol),
        .rx_preamble_err(pe), .rx_delimiter_err(de));
    efm_pkt_sink efm_pkt_sink_i (.clk(clk), .stall_on(stall), .ready(tor));
    always #4 clk = ~clk;
    always @(posedge clk)
    begin
        if (tov === 1'b1 && tor) txq.push_back(tod);
        if (tov === 1'b1 && tor && tol) ntl++;
        // Position of the last flag, so a last on the wrong byte is caught.
        if (tov === 1'b1 && tor && tol) tla = txq.size();
        if (rov === 1'b1) rxq.push_back(rod);
        if (rov === 1'b1 && rol) nrl++;
        if (rov === 1'b1 && rol) rla = rxq.size();
        if (good === 1'b1) ng++;
        if (bad === 1'b1) nb++;
        if (stomp === 1'b1) ns++;
        if (pe === 1'b1) npe++;
        if (de === 1'b1) nde++;
    end
    task automatic chk(logic [63:0] s, logic [63:0] e);
        n_compared++;
        if (s !== e)
        begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic cmpq(b_t s[$], b_t e[$]);
        chk(s.size(), e.size());
        foreach (e[k]) chk(s[k], e[k]);
    endtask
    function automatic logic [31:0] crc(b_t q[$]);
        logic [31:0] c = `EFM_CRC_INIT;
        foreach (q[i])
        begin
            c ^= 32'(q[i]);
            repeat (8) c = c[0] ? (c >> 1) ^ `EFM_CRC_POLY : c >> 1;
        end
        return ~c;
    endfunction
    task automatic idle(int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic send(bit rx, b_t q[$]);
        foreach (q[i])
        begin
            @(negedge clk);
            {rv, tv} = {rx, !rx};
            {rd, td} = {q[i], q[i]};
            {rl, tl} = {2{i == q.size() - 1}};
            do @(posedge clk); while ((rx ? rir : tir) !== 1'b1);
        end
        @(negedge clk);
        {rv, tv, rl, tl} = 4'h0;
    endtask
    task automatic tx_frame(int n, bit i, bit g, bit bd);
        b_t q[$], e[$];
        logic [31:0] c;
        txq.delete();
        {ng, nb, ns, ntl} = '0;
        ins = i;
        ign = g;
        repeat (n) q.push_back(b_t'($urandom));
        c = crc(q);
        // Insertion off: the bench appends the FCS, flipping bit 0 of each FCS byte for a bad one.
        if (!i) for (int k = 0; k < 4; k++) q.push_back(c[8*k+:8] ^ {7'h00, bd});
        e = q;
        if (i) for (int k = 0; k < 4; k++) e.push_back(c[8*k+:8]);
        send(0, q);
        for (int k = 0; k < 400 && ntl == 0; k++) @(negedge clk);
        idle(3);
        cmpq(txq, e);
        chk(ntl, 1);
        chk(tla, e.size());
        chk(ng, i || !bd || g);
        chk(nb, !i && bd && !g);
        chk(ns, !i && bd && !g);
    endtask
    task automatic rx_frame(int n, bit bp);
        b_t q[$], e[$];
        rxq.delete();
        {npe, nde, nrl} = '0;
        repeat (7) q.push_back(`EFM_PREAMBLE_BYTE);
        q[3] ^= {7'h00, bp};
        q.push_back(`EFM_DELIM_BYTE ^ {bp, 7'h00});
        repeat (n) e.push_back(b_t'($urandom));
        q = {q, e};
        if (strip && n > 8) e = e[0:n-5];
        send(1, q);
        idle(10);
        cmpq(rxq, e);
        chk(nrl, 1);
        chk(rla, e.size());
        chk(npe, pv && bp);
        chk(nde, dv && bp);
    endtask
    task automatic mk_run(int n);
        logic [4:0] pl;
        int gap;
        for (int p = 0; p <= n; p++)
        begin
            gap = 0;
            do
            begin
                @(negedge clk);
                gap++;
            end while (mv !== 1'b1 && gap < sp + 40);
            if (p > 0) chk(gap, sp + 2);
            if (p > 0) chk(ml, pl == 19 ? 5'h00 : pl + 5'h01);
            chk(md,
                cus ? mk[64*ml+:64] : dflt[ml]);
            pl = ml;
        end
    endtask
    task automatic conclude();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        #600000;
        failures++;
        conclude();
    end
    initial
    begin
        void'($urandom(32'hE8F71BF3));
        for (int k = 0; k < 40; k++) mk[32*k+:32] = $urandom;
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst_n = 1;
        mk_run(21);
        cus = 1;
        sp = 16'h0009;
        mk_run(21);
        // Two full gaps at the default spacing; these dominate the run time.
        sp = `EFM_SPACING_DEFAULT;
        mk_run(1);
        for (int k = 0; k < 16; k++)
        begin
            stall = k > 7;
            tx_frame(k % 8 == 0 ? 1 : 1 + $urandom_range(30), k[0], k[1], k[2]);
        end
        for (int k = 0; k < 32; k++)
        begin
            {pv, dv, strip} = k[2:0];
            rx_frame(k[4] ? 8 : 9 + $urandom_range(6), k[3]);
        end
        conclude();
    end
endmodule
